//--- rtl/cism_defines.vh
/*
  Constants for the processor interrupt source map: private line indices,
  shared line indices, message translation offset and debug state codes.
  Assumes it is included by bare name from the design files of this block.
*/
`ifndef CISM_DEFINES_VH
`define CISM_DEFINES_VH

// Widths of the line vectors
`define CISM_NUM_CORES 2
`define CISM_PRIV_W 16
`define CISM_SOFT_W 16
`define CISM_SHARED_W 156

// Private line indices, per core
`define CISM_PRIV_NS_TIMER 4'he
`define CISM_PRIV_S_TIMER 4'hd
`define CISM_PRIV_VIRT_TIMER 4'hb
`define CISM_PRIV_HYP_TIMER 4'ha
`define CISM_PRIV_VCPU_MAINT 4'h9
`define CISM_PRIV_PMU_OVF 4'h7

// Shared line indices
`define CISM_SH_EXT0 8'h00
`define CISM_SH_EXT1 8'h01
`define CISM_SH_RSVD_A 8'h02
`define CISM_SH_CARD_WAKE 8'h03
`define CISM_SH_CARD 8'h04
`define CISM_SH_WATCHDOG 8'h05
`define CISM_SH_TIMER_LO 8'h06
`define CISM_SH_TIMER_HI 8'h08
`define CISM_SH_UART_LO 8'h09
`define CISM_SH_UART_HI 8'h0a
`define CISM_SH_TWO_WIRE 8'h0b
`define CISM_SH_TWO_WIRE2 8'h0c
`define CISM_SH_SER_MASTER 8'h0d
`define CISM_SH_AUX_LOCK 8'h0e
`define CISM_SH_MBOX_LO 8'h0f
`define CISM_SH_MBOX_HI 8'h10
`define CISM_SH_SER_PIN_LO 8'h11
`define CISM_SH_SER_PIN_HI 8'h13
`define CISM_SH_PAR_GPIO 8'h14
`define CISM_SH_MGMT_LO 8'h15
`define CISM_SH_MGMT_HI 8'h18
`define CISM_SH_FRAME_DMA 8'h19
`define CISM_SH_ANALYZER 8'h1a
`define CISM_SH_TS_READY 8'h1b
`define CISM_SH_TIME_SYNC 8'h1c
`define CISM_SH_MEM_INTEG 8'h1d
`define CISM_SH_XTR_READY 8'h1e
`define CISM_SH_INJ_READY 8'h1f
`define CISM_SH_PCIE 8'h20
`define CISM_SH_RSVD_B 8'h21
`define CISM_SH_EGR_ACL 8'h22
`define CISM_SH_REWRITER 8'h23
`define CISM_SH_MEM_CTRL 8'h24
`define CISM_SH_SOFT_LO 8'h25
`define CISM_SH_SOFT_HI 8'h2e
`define CISM_SH_FAST_SD_LO 8'h2f
`define CISM_SH_FAST_SD_HI 8'h42
`define CISM_SH_MID_SD_LO 8'h43
`define CISM_SH_MID_SD_HI 8'h4f
`define CISM_SH_PORT_LO 8'h50
`define CISM_SH_PORT_HI 8'h90
`define CISM_SH_CACHE_ECC 8'h91
`define CISM_SH_BUS_ERR 8'h92
`define CISM_SH_LEG_D 8'h93
`define CISM_SH_LEG_C 8'h94
`define CISM_SH_LEG_B 8'h95
`define CISM_SH_LEG_A 8'h96
`define CISM_SH_RC_SYS_ERR 8'h97
`define CISM_SH_RC_PME 8'h98
`define CISM_SH_RC_AER 8'h99
`define CISM_SH_RC_SII 8'h9a
`define CISM_SH_RC_WAKE 8'h9b

// Message translation register offset in the endpoint write window
`define CISM_MSG_XLATE_OFFSET 16'h0040

// Reset values
`define CISM_SHARED_RST 156'h0
`define CISM_PRIV_RST 32'h0
`define CISM_SOFT_RST 32'h0
`define CISM_MSG_ID_RST 16'h0000

// Debug port owner states, one-hot
`define CISM_DBG_IDLE 4'h1
`define CISM_DBG_JTAG 4'h2
`define CISM_DBG_CORE0 4'h4
`define CISM_DBG_CORE1 4'h8

`endif

//--- rtl/cism_sync.v
/*
  Two-stage synchroniser for a vector of level signals.
  Assumes its inputs come from outside the clock domain and change slowly
  enough that each bit is caught on its own; no bus coherence is offered.
*/
module cism_sync #(
  parameter WIDTH = 1
) (
  input wire clock,
  input wire nrst,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_r; // First stage, read only by the second stage
  reg [WIDTH-1:0] hold_r; // Second stage, safe to use

  // Two flip-flops in series per bit
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meta_r <= {WIDTH{1'b0}};
      hold_r <= {WIDTH{1'b0}};
    end else begin
      meta_r <= async_in;
      hold_r <= meta_r;
    end
  end

  assign sync_out = hold_r;

endmodule // cism_sync

//--- rtl/cism_top.v
/*
  Interrupt source map for the dual-core processor: gathers per-core private
  sources, chip-wide shared sources, software-generated requests and
  endpoint message writes into the line vectors seen by the cores, and
  chooses the owner of the debug access port.
  Assumes private sources, software requests and message writes arrive on
  this clock; shared sources and the external debug request may not.
  Shared levels show on their line three edges after they change: two for
  the synchroniser, one for the output register. A shared pulse shorter
  than about one cycle may be lost.
  Private levels, software pulses and message pulses show one edge later.
  Software pulses are not held pending: a line stands only while its request is held.
  The debug port keeps its owner until that owner drops its request.
  A new owner is granted only after one idle cycle.
*/
// Overview of operation
// [R1] - Accept software, private, shared and message interrupts
// [R2] - Either core raises software interrupts, no source line
// [R3] - Private timers at 14, 13, 11, 10
// [R4] - Private maintenance at 9, monitor overflow at 7
// [R5] - Shared 0,1 external pins; 2 reserved
// [R6] - Card host wake on 3, normal on 4
// [R7] - Watchdog on 5, timers on 6 to 8
// [R8] - UARTs 9,10; two-wire 11,12; serial master 13
// [R9] - Auxiliary lock 14, mailbox software 15,16
// [R10] - Serial pin 17 to 19, parallel GPIO 20
// [R11] - Management controllers 0 to 3 on 21 to 24
// [R12] - Frame DMA 25, analyzer 26, timestamp 27, sync 28
// [R13] - Integrity 29, extraction 30, injection 31
// [R14] - PCIe 32, egress ACL 34, rewriter 35, memory 36
// [R15] - Soft 46:37, serdes 66:47, 79:67, ports 144:80
// [R16] - Cache ECC fatal 145, bus error 146
// [R17] - Legacy D,C,B,A on 147 to 150
// [R18] - Root complex errors and wake on 151 to 155
// [R19] - Translation register write becomes processor interrupt
// [R20] - JTAG and self-hosted debug share one port
// [R21] - Unassigned shared lines stay inactive
`include "cism_defines.vh"

module cism_top (
  input wire clock,
  input wire nrst,
  // Per-core private sources, bit n belongs to core n
  input wire [1:0] ns_timer_irq,
  input wire [1:0] s_timer_irq,
  input wire [1:0] virt_timer_irq,
  input wire [1:0] hyp_timer_irq,
  input wire [1:0] vcpu_maint_irq,
  input wire [1:0] pmu_overflow_irq,
  // Software-generated requests, one per issuing core
  input wire [1:0] soft_req,
  input wire [3:0] soft_id_c0,
  input wire [1:0] soft_target_c0,
  input wire [3:0] soft_id_c1,
  input wire [1:0] soft_target_c1,
  // Shared sources from across the chip
  input wire external_pin_irq_0,
  input wire external_pin_irq_1,
  input wire card_host_wake_irq,
  input wire card_host_irq,
  input wire watchdog_irq,
  input wire [2:0] gen_timer_irq,
  input wire [1:0] uart_irq,
  input wire two_wire_irq,
  input wire two_wire_second_irq,
  input wire serial_master_irq,
  input wire aux_processor_lock_irq,
  input wire mailbox_soft_irq_0,
  input wire mailbox_soft_irq_1,
  input wire [2:0] serial_pin_irq,
  input wire parallel_gpio_irq,
  input wire [3:0] mgmt_serial_irq,
  input wire frame_dma_irq,
  input wire analyzer_irq,
  input wire timestamp_ready_irq,
  input wire time_sync_irq,
  input wire memory_integrity_irq,
  input wire extraction_ready_irq,
  input wire injection_ready_irq,
  input wire pcie_irq,
  input wire egress_acl_irq,
  input wire rewriter_irq,
  input wire mem_ctrl_irq,
  input wire [9:0] shared_soft_irqs,
  input wire [19:0] fast_serdes_irqs,
  input wire [12:0] mid_serdes_irqs,
  input wire [64:0] port_module_irqs,
  input wire cache_ecc_fatal_irq,
  input wire bus_external_error_irq,
  input wire [3:0] pcie_legacy_irq,
  input wire pcie_rc_sys_err_irq,
  input wire pcie_rc_pme_irq,
  input wire pcie_rc_aer_irq,
  input wire pcie_rc_sii_irq,
  input wire pcie_rc_wake_irq,
  // Endpoint write towards the message translation register
  input wire msg_wr_valid,
  input wire [15:0] msg_wr_addr,
  input wire [15:0] msg_wr_data,
  // Debug access requests
  input wire jtag_dbg_req,
  input wire [1:0] core_dbg_req,
  // Line vectors towards the cores
  output reg [31:0] private_core_irq,
  output reg [31:0] software_generated_irq,
  output reg [155:0] shared_irq,
  output reg message_based_irq_valid,
  output reg [15:0] message_based_irq_id,
  output reg msg_wr_miss,
  // Debug port owner
  output reg dbg_sel_jtag,
  output reg [1:0] dbg_sel_core
);

  reg [155:0] shared_raw; // Shared sources placed at their line index
  wire [155:0] shared_sync; // Shared sources after two flip-flops
  wire jtag_req_sync; // External debug request after two flip-flops
  wire [31:0] private_nxt; // Private vector for both cores
  wire [31:0] soft_nxt; // Software-generated pulses for both cores
  reg [3:0] dbg_state_r; // Debug owner state, one-hot
  reg [3:0] dbg_state_nxt; // Next debug owner state
  wire msg_hit; // Write lands on the translation register

  // Debug owner states, one-hot
  localparam [3:0] DBG_IDLE = `CISM_DBG_IDLE; // Port free
  localparam [3:0] DBG_JTAG = `CISM_DBG_JTAG; // Held by the external probe
  localparam [3:0] DBG_CORE0 = `CISM_DBG_CORE0; // Self-hosted session of core 0
  localparam [3:0] DBG_CORE1 = `CISM_DBG_CORE1; // Self-hosted session of core 1

  // Place each shared source on its line
  always @* begin
    shared_raw = `CISM_SHARED_RST; // [R21]
    shared_raw[`CISM_SH_EXT0] = external_pin_irq_0; // [R5]
    shared_raw[`CISM_SH_EXT1] = external_pin_irq_1; // [R5]
    // Card host, watchdog and general timers
    shared_raw[`CISM_SH_CARD_WAKE] = card_host_wake_irq; // [R6]
    shared_raw[`CISM_SH_CARD] = card_host_irq; // [R6]
    shared_raw[`CISM_SH_WATCHDOG] = watchdog_irq; // [R7]
    shared_raw[`CISM_SH_TIMER_HI:`CISM_SH_TIMER_LO] = gen_timer_irq; // [R7]
    // Serial controllers, lock and mailbox lines
    shared_raw[`CISM_SH_UART_HI:`CISM_SH_UART_LO] = uart_irq; // [R8]
    shared_raw[`CISM_SH_TWO_WIRE] = two_wire_irq; // [R8]
    shared_raw[`CISM_SH_TWO_WIRE2] = two_wire_second_irq; // [R8]
    shared_raw[`CISM_SH_SER_MASTER] = serial_master_irq; // [R8]
    shared_raw[`CISM_SH_AUX_LOCK] = aux_processor_lock_irq; // [R9]
    shared_raw[`CISM_SH_MBOX_LO] = mailbox_soft_irq_0; // [R9]
    shared_raw[`CISM_SH_MBOX_HI] = mailbox_soft_irq_1; // [R9]
    // Pin controllers and management buses
    shared_raw[`CISM_SH_SER_PIN_HI:`CISM_SH_SER_PIN_LO] = serial_pin_irq; // [R10]
    shared_raw[`CISM_SH_PAR_GPIO] = parallel_gpio_irq; // [R10]
    shared_raw[`CISM_SH_MGMT_HI:`CISM_SH_MGMT_LO] = mgmt_serial_irq; // [R11]
    // Switch core sources
    shared_raw[`CISM_SH_FRAME_DMA] = frame_dma_irq; // [R12]
    shared_raw[`CISM_SH_ANALYZER] = analyzer_irq; // [R12]
    shared_raw[`CISM_SH_TS_READY] = timestamp_ready_irq; // [R12]
    shared_raw[`CISM_SH_TIME_SYNC] = time_sync_irq; // [R12]
    shared_raw[`CISM_SH_MEM_INTEG] = memory_integrity_irq; // [R13]
    shared_raw[`CISM_SH_XTR_READY] = extraction_ready_irq; // [R13]
    shared_raw[`CISM_SH_INJ_READY] = injection_ready_irq; // [R13]
    shared_raw[`CISM_SH_PCIE] = pcie_irq; // [R14]
    shared_raw[`CISM_SH_EGR_ACL] = egress_acl_irq; // [R14]
    shared_raw[`CISM_SH_REWRITER] = rewriter_irq; // [R14]
    shared_raw[`CISM_SH_MEM_CTRL] = mem_ctrl_irq; // [R14]
    // Wide groups: shared software, serdes and port modules
    shared_raw[`CISM_SH_SOFT_HI:`CISM_SH_SOFT_LO] = shared_soft_irqs; // [R15]
    shared_raw[`CISM_SH_FAST_SD_HI:`CISM_SH_FAST_SD_LO] = fast_serdes_irqs; // [R15]
    shared_raw[`CISM_SH_MID_SD_HI:`CISM_SH_MID_SD_LO] = mid_serdes_irqs; // [R15]
    shared_raw[`CISM_SH_PORT_HI:`CISM_SH_PORT_LO] = port_module_irqs; // [R15]
    // Processor error lines
    shared_raw[`CISM_SH_CACHE_ECC] = cache_ecc_fatal_irq; // [R16]
    shared_raw[`CISM_SH_BUS_ERR] = bus_external_error_irq; // [R16]
    // Legacy lines run in reverse letter order, bit 0 is A
    shared_raw[`CISM_SH_LEG_D] = pcie_legacy_irq[3]; // [R17]
    shared_raw[`CISM_SH_LEG_C] = pcie_legacy_irq[2]; // [R17]
    shared_raw[`CISM_SH_LEG_B] = pcie_legacy_irq[1]; // [R17]
    shared_raw[`CISM_SH_LEG_A] = pcie_legacy_irq[0]; // [R17]
    // Root complex lines
    shared_raw[`CISM_SH_RC_SYS_ERR] = pcie_rc_sys_err_irq; // [R18]
    shared_raw[`CISM_SH_RC_PME] = pcie_rc_pme_irq; // [R18]
    shared_raw[`CISM_SH_RC_AER] = pcie_rc_aer_irq; // [R18]
    shared_raw[`CISM_SH_RC_SII] = pcie_rc_sii_irq; // [R18]
    shared_raw[`CISM_SH_RC_WAKE] = pcie_rc_wake_irq; // [R18]
  end

  // Shared sources live in other domains, so bring them over first
  // Lines 2 and 33 enter as constant zero
  cism_sync #(
    .WIDTH(`CISM_SHARED_W)
  ) u_shared_sync (
    .clock(clock),
    .nrst(nrst),
    .async_in(shared_raw),
    .sync_out(shared_sync)
  );

  // External debug request arrives from the pins
  cism_sync #(
    .WIDTH(1)
  ) u_jtag_sync (
    .clock(clock),
    .nrst(nrst),
    .async_in(jtag_dbg_req),
    .sync_out(jtag_req_sync)
  );

  // Register the shared vector; unassigned lines are forced low again
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      // All lines quiet in reset
      shared_irq <= `CISM_SHARED_RST;
    end else begin
      shared_irq <= shared_sync; // [R1]
      shared_irq[`CISM_SH_RSVD_A] <= 1'b0; // [R21] [R5]
      shared_irq[`CISM_SH_RSVD_B] <= 1'b0; // [R21] [R14]
    end
  end

  // Per-core private vector and software pulses, one slice per core
  genvar gc;
  generate
    for (gc = 0; gc < `CISM_NUM_CORES; gc = gc + 1) begin : g_core
      reg [15:0] core_priv; // Private lines of this core
      reg [15:0] core_soft; // Software pulses aimed at this core

      // Private lines for this core
      always @* begin
        core_priv = 16'h0000; // Unlisted private lines stay low
        core_priv[`CISM_PRIV_NS_TIMER] = ns_timer_irq[gc]; // [R3]
        core_priv[`CISM_PRIV_S_TIMER] = s_timer_irq[gc]; // [R3]
        core_priv[`CISM_PRIV_VIRT_TIMER] = virt_timer_irq[gc]; // [R3]
        core_priv[`CISM_PRIV_HYP_TIMER] = hyp_timer_irq[gc]; // [R3]
        core_priv[`CISM_PRIV_VCPU_MAINT] = vcpu_maint_irq[gc]; // [R4]
        core_priv[`CISM_PRIV_PMU_OVF] = pmu_overflow_irq[gc]; // [R4]
      end

      // Software pulses aimed at this core from either issuer
      always @* begin
        core_soft = 16'h0000; // No request, no pulse
        // Issuer core 0
        if (soft_req[0] && soft_target_c0[gc]) begin
          core_soft[soft_id_c0] = 1'b1; // [R2]
        end
        // Issuer core 1, may hit the same line in the same cycle
        if (soft_req[1] && soft_target_c1[gc]) begin
          core_soft[soft_id_c1] = 1'b1; // [R2]
        end
      end

      // Each core owns one slice, so every bit has a single driver
      assign private_nxt[gc*16 +: 16] = core_priv;
      assign soft_nxt[gc*16 +: 16] = core_soft;
    end
  endgenerate

  // Register private levels and software pulses
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      // Every line low in reset
      private_core_irq <= `CISM_PRIV_RST;
      software_generated_irq <= `CISM_SOFT_RST;
    end else begin
      // Levels and pulses show one edge after their sources
      private_core_irq <= private_nxt; // [R1]
      software_generated_irq <= soft_nxt; // [R1] [R2]
    end
  end

  // Only a write to the translation register raises a message interrupt
  assign msg_hit = msg_wr_addr == `CISM_MSG_XLATE_OFFSET;

  // Turn each write to the translation register into a one-cycle interrupt with its event id
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      // No pulse and no event id before the first write
      message_based_irq_valid <= 1'b0;
      message_based_irq_id <= `CISM_MSG_ID_RST;
      msg_wr_miss <= 1'b0;
    end else begin
      message_based_irq_valid <= msg_wr_valid && msg_hit; // [R19] [R1]
      // A write to any other offset only raises the miss pulse
      msg_wr_miss <= msg_wr_valid && !msg_hit;
      // Event id is kept until the next accepted write
      if (msg_wr_valid && msg_hit) begin
        message_based_irq_id <= msg_wr_data; // [R19]
      end
    end
  end

  // Debug port owner: JTAG wins over cores, core 0 over core 1
  always @* begin
    dbg_state_nxt = dbg_state_r;
    case (dbg_state_r)
      DBG_IDLE: begin
        // Grant only from idle, so no session is cut short
        if (jtag_req_sync) begin
          dbg_state_nxt = DBG_JTAG; // [R20]
        end else if (core_dbg_req[0]) begin
          dbg_state_nxt = DBG_CORE0; // [R20]
        end else if (core_dbg_req[1]) begin
          dbg_state_nxt = DBG_CORE1; // [R20]
        end
      end
      DBG_JTAG: begin
        // Held until the external request drops
        if (!jtag_req_sync) begin
          dbg_state_nxt = DBG_IDLE;
        end
      end
      DBG_CORE0: begin
        // Self-hosted session ends when the core lets go
        if (!core_dbg_req[0]) begin
          dbg_state_nxt = DBG_IDLE;
        end
      end
      DBG_CORE1: begin
        // Same for core 1
        if (!core_dbg_req[1]) begin
          dbg_state_nxt = DBG_IDLE;
        end
      end
      default: begin
        // Recover from an illegal code
        dbg_state_nxt = DBG_IDLE;
      end
    endcase
  end

  // Debug state and port select outputs
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      // Port free, nothing selected
      dbg_state_r <= DBG_IDLE;
      dbg_sel_jtag <= 1'b0;
      dbg_sel_core <= 2'h0;
    end else begin
      dbg_state_r <= dbg_state_nxt;
      // Selects follow the next state so they line up with it
      dbg_sel_jtag <= dbg_state_nxt == DBG_JTAG; // [R20]
      dbg_sel_core[0] <= dbg_state_nxt == DBG_CORE0; // [R20]
      dbg_sel_core[1] <= dbg_state_nxt == DBG_CORE1; // [R20]
    end
  end

endmodule // cism_top

//--- sim/cism_chk.sv
/* Checker for the interrupt source map outputs.
   Assumes it is bound into cism_top and sees only its ports. */
`include "cism_defines.vh"
module cism_chk (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [1:0] ns_timer_irq,
  input wire logic [1:0] vcpu_maint_irq,
  input wire logic [1:0] pmu_overflow_irq,
  input wire logic [1:0] soft_req,
  input wire logic [3:0] soft_id_c0,
  input wire logic [1:0] soft_target_c0,
  input wire logic watchdog_irq,
  input wire logic cache_ecc_fatal_irq,
  input wire logic bus_external_error_irq,
  input wire logic [3:0] pcie_legacy_irq,
  input wire logic msg_wr_valid,
  input wire logic [15:0] msg_wr_addr,
  input wire logic [15:0] msg_wr_data,
  input wire logic [1:0] core_dbg_req,
  input wire logic [31:0] private_core_irq,
  input wire logic [31:0] software_generated_irq,
  input wire logic [155:0] shared_irq,
  input wire logic message_based_irq_valid,
  input wire logic [15:0] message_based_irq_id,
  input wire logic msg_wr_miss,
  input wire logic dbg_sel_jtag,
  input wire logic [1:0] dbg_sel_core
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // Edges since reset release, so history never reaches into reset
  logic [1:0] live_r;
  // Counts up to three and stays
  always @(posedge clock or negedge nrst) begin
    if (!nrst) live_r <= 2'h0;
    else if (live_r != 2'h3) live_r <= live_r + 2'h1;
  end
  a_ns_timer_map: assert property (live_r != 2'h0 |-> private_core_irq[14] ==
    $past(ns_timer_irq[0]) && private_core_irq[30] == $past(ns_timer_irq[1]))
    else $error("ns timer line wrong");
  a_maint_pmu_map: assert property (live_r != 2'h0 |-> private_core_irq[9] ==
    $past(vcpu_maint_irq[0]) && private_core_irq[23] == $past(pmu_overflow_irq[1]))
    else $error("maintenance or overflow line wrong");
  a_priv_unused_low: assert property ((private_core_irq & ~32'h6e806e80) == 32'h0)
    else $error("unused private line set");
  a_watchdog_line: assert property (live_r == 2'h3 |->
    shared_irq[5] == $past(watchdog_irq, 3)) else $error("watchdog line wrong");
  a_error_lines: assert property (live_r == 2'h3 |-> shared_irq[145] ==
    $past(cache_ecc_fatal_irq, 3) && shared_irq[146] == $past(bus_external_error_irq, 3))
    else $error("error lines wrong");
  a_legacy_order: assert property (live_r == 2'h3 |-> shared_irq[147] ==
    $past(pcie_legacy_irq[3], 3) && shared_irq[150] == $past(pcie_legacy_irq[0], 3))
    else $error("legacy order wrong");
  a_spare_idle: assert property (!shared_irq[2] && !shared_irq[33])
    else $error("unassigned line active");
  a_soft_target: assert property (soft_req[0] && soft_target_c0[1] |=>
    software_generated_irq[{1'b1, $past(soft_id_c0)}]) else $error("soft line missing");
  a_soft_quiet: assert property (soft_req == 2'h0 |=> software_generated_irq == 32'h0)
    else $error("soft pulse without request");
  a_msg_accept: assert property (msg_wr_valid && msg_wr_addr == `CISM_MSG_XLATE_OFFSET
    |=> message_based_irq_valid && !msg_wr_miss && message_based_irq_id == $past(msg_wr_data))
    else $error("message write not raised");
  a_msg_miss: assert property (msg_wr_valid && msg_wr_addr != `CISM_MSG_XLATE_OFFSET
    |=> msg_wr_miss && !message_based_irq_valid) else $error("miss not flagged");
  a_dbg_hold: assert property (dbg_sel_core[0] && core_dbg_req[0] |=>
    dbg_sel_core[0] && !dbg_sel_jtag) else $error("debug owner lost");
endmodule // cism_chk
bind cism_top cism_chk chk (.*);

//--- sim/cism_src_model.sv
/* Bank of chip-wide interrupt sources feeding the shared lines.
   Assumes src bits follow the port order of the shared inputs. */
module cism_src_model (
  input wire logic [153:0] src,
  output logic [153:0] drv
);
  timeunit 1ns;
  timeprecision 1ns;
  // Sources are unrelated to the clock, so levels move off the edge
  initial drv = 154'h0;
  always @(src) drv <= #3 src;
endmodule // cism_src_model

//--- sim/cism_top_bench.sv
/* Self-checking bench for the interrupt source map.
   Assumes cism_top with the checker bound and the source bank model. */
`include "cism_defines.vh"
module cism_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [11:0] psrc = 12'h0;
  logic [153:0] src = 154'h0;
  logic [1:0] soft_req = 2'h0, soft_target_c0 = 2'h0, soft_target_c1 = 2'h0;
  logic [3:0] soft_id_c0 = 4'h0, soft_id_c1 = 4'h0;
  logic msg_wr_valid = 1'b0, jtag_dbg_req = 1'b0;
  logic [15:0] msg_wr_addr = 16'h0, msg_wr_data = 16'h0;
  logic [1:0] core_dbg_req = 2'h0;
  int mismatches = 0, n_compared = 0;
  wire [1:0] ns_timer_irq, s_timer_irq, virt_timer_irq, hyp_timer_irq, vcpu_maint_irq;
  wire [1:0] pmu_overflow_irq, uart_irq, dbg_sel_core;
  wire external_pin_irq_0, external_pin_irq_1, card_host_wake_irq, card_host_irq;
  wire watchdog_irq, two_wire_irq, two_wire_second_irq, serial_master_irq;
  wire aux_processor_lock_irq, mailbox_soft_irq_0, mailbox_soft_irq_1, parallel_gpio_irq;
  wire frame_dma_irq, analyzer_irq, timestamp_ready_irq, time_sync_irq, memory_integrity_irq;
  wire extraction_ready_irq, injection_ready_irq, pcie_irq, egress_acl_irq, rewriter_irq;
  wire mem_ctrl_irq, cache_ecc_fatal_irq, bus_external_error_irq, pcie_rc_sys_err_irq;
  wire pcie_rc_pme_irq, pcie_rc_aer_irq, pcie_rc_sii_irq, pcie_rc_wake_irq;
  wire [2:0] gen_timer_irq, serial_pin_irq;
  wire [3:0] mgmt_serial_irq, pcie_legacy_irq;
  wire [9:0] shared_soft_irqs;
  wire [19:0] fast_serdes_irqs;
  wire [12:0] mid_serdes_irqs;
  wire [64:0] port_module_irqs;
  wire [153:0] drv;
  wire [31:0] private_core_irq, software_generated_irq;
  wire [155:0] shared_irq;
  wire [15:0] message_based_irq_id;
  wire message_based_irq_valid, msg_wr_miss, dbg_sel_jtag;
  // Source bank bits spread over the shared inputs in port order
  assign {pcie_rc_wake_irq, pcie_rc_sii_irq, pcie_rc_aer_irq, pcie_rc_pme_irq,
    pcie_rc_sys_err_irq, pcie_legacy_irq, bus_external_error_irq, cache_ecc_fatal_irq,
    port_module_irqs, mid_serdes_irqs, fast_serdes_irqs, shared_soft_irqs, mem_ctrl_irq,
    rewriter_irq, egress_acl_irq, pcie_irq, injection_ready_irq, extraction_ready_irq,
    memory_integrity_irq, time_sync_irq, timestamp_ready_irq, analyzer_irq, frame_dma_irq,
    mgmt_serial_irq, parallel_gpio_irq, serial_pin_irq, mailbox_soft_irq_1,
    mailbox_soft_irq_0, aux_processor_lock_irq, serial_master_irq, two_wire_second_irq,
    two_wire_irq, uart_irq, gen_timer_irq, watchdog_irq, card_host_irq, card_host_wake_irq,
    external_pin_irq_1, external_pin_irq_0} = drv;
  // Two bits per private source kind, bit n for core n
  assign {pmu_overflow_irq, vcpu_maint_irq, hyp_timer_irq, virt_timer_irq, s_timer_irq,
    ns_timer_irq} = psrc;
  cism_src_model src_m (.src(src), .drv(drv));
  cism_top uut (.*);
  always #5 clock = ~clock;

  // Counts and reports one comparison
  task automatic chk(logic [155:0] got, logic [155:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Expected shared line of a source bank bit
  function automatic int line_of(int s);
    if (s < 2) return s;
    if (s < 32) return s + 1;
    if (s < 145) return s + 2;
    if (s < 149) return 295 - s;
    return s + 2;
  endfunction

  task automatic t_private();
    int idx[6] = '{14, 13, 11, 10, 9, 7};
    for (int k = 0; k < 6; k++) begin
      for (int c = 0; c < 2; c++) begin
        @(negedge clock);
        psrc = 12'h1 << (2 * k + c);
        @(negedge clock);
        chk(private_core_irq, 32'h1 << (16 * c + idx[k]));
      end
    end
    psrc = 12'hfff;
    @(negedge clock);
    chk(private_core_irq, 32'h6e806e80);
    psrc = 12'h0;
  endtask

  task automatic t_shared();
    logic [155:0] e;
    for (int s = 0; s < 154; s++) begin
      e = 156'h0;
      e[line_of(s)] = 1'b1;
      src = 154'h1 << s;
      repeat (4) @(negedge clock);
      chk(shared_irq, e);
    end
    e = ~156'h0;
    e[2] = 1'b0;
    e[33] = 1'b0;
    src = ~154'h0;
    repeat (4) @(negedge clock);
    chk(shared_irq, e);
    src = 154'h0;
  endtask

  // Checks the previous request's pulse, then drives the next
  task automatic soft_step(logic [1:0] r, logic [3:0] i0, logic [1:0] t0, logic [3:0] i1,
    logic [1:0] t1, logic [31:0] e);
    @(negedge clock);
    chk(software_generated_irq, e);
    soft_req = r;
    soft_id_c0 = i0;
    soft_target_c0 = t0;
    soft_id_c1 = i1;
    soft_target_c1 = t1;
  endtask

  task automatic t_soft();
    logic [31:0] e;
    e = 32'h0;
    for (int i = 0; i < 16; i++) begin
      soft_step(2'h3, i[3:0], 2'h1, 4'hf - i[3:0], 2'h2, e);
      e = (32'h1 << i) | (32'h1 << (31 - i));
    end
    soft_step(2'h1, 4'h3, 2'h3, 4'h0, 2'h0, e);
    soft_step(2'h0, 4'h0, 2'h0, 4'h0, 2'h0, 32'h00080008);
    soft_step(2'h0, 4'h0, 2'h0, 4'h0, 2'h0, 32'h0);
  endtask

  // Checks the previous write's answer, then drives the next
  task automatic msg_step(logic v, logic [15:0] a, logic [15:0] d, logic ev, logic em,
    logic [15:0] eid);
    @(negedge clock);
    chk({message_based_irq_valid, msg_wr_miss, message_based_irq_id}, {ev, em, eid});
    msg_wr_valid = v;
    msg_wr_addr = a;
    msg_wr_data = d;
  endtask

  task automatic t_msg();
    msg_step(1'b1, `CISM_MSG_XLATE_OFFSET, 16'h2001, 1'b0, 1'b0, 16'h0);
    msg_step(1'b1, 16'h0044, 16'h5555, 1'b1, 1'b0, 16'h2001);
    msg_step(1'b1, `CISM_MSG_XLATE_OFFSET, 16'hbeef, 1'b0, 1'b1, 16'h2001);
    msg_step(1'b0, `CISM_MSG_XLATE_OFFSET, 16'h1234, 1'b1, 1'b0, 16'hbeef);
    msg_step(1'b0, 16'h0, 16'h0, 1'b0, 1'b0, 16'hbeef);
  endtask

  // Drives debug requests, waits the given number of cycles, checks the owner
  task automatic dbg_step(logic j, logic [1:0] c, int w, logic [2:0] e);
    @(negedge clock);
    jtag_dbg_req = j;
    core_dbg_req = c;
    repeat (w) @(negedge clock);
    chk({dbg_sel_jtag, dbg_sel_core}, e);
  endtask

  task automatic t_debug();
    dbg_step(1'b0, 2'h1, 1, 3'h1);
    dbg_step(1'b1, 2'h3, 4, 3'h1);
    dbg_step(1'b1, 2'h2, 1, 3'h0);
    dbg_step(1'b1, 2'h2, 1, 3'h4);
    dbg_step(1'b0, 2'h2, 4, 3'h2);
    dbg_step(1'b0, 2'h0, 2, 3'h0);
  endtask

  initial begin
    repeat (4) @(posedge clock);
    @(negedge clock);
    nrst = 1'b1;
    repeat (2) @(negedge clock);
    t_private();
    t_shared();
    t_soft();
    t_msg();
    t_debug();
    give_verdict();
  end

  // Cuts a hang short
  initial begin
    repeat (100000) @(posedge clock);
    mismatches++;
    give_verdict();
  end
endmodule // cism_top_bench
